// file: bench/imr_master_sva.sv
// Purpose: Port-level checks for the two-wire master sequencer
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every imr_master instance
`timescale 1ns/1ps
module imr_master_sva #(
    parameter QTR_BASE = 25
) (
    input wire        CLK_I,
    input wire        RST_N_I,
    input wire [4:0]  AVS_ADDRESS_I,
    input wire        AVS_READ_I,
    input wire        AVS_WRITE_I,
    input wire [3:0]  AVS_BYTEENABLE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [31:0] AVS_READDATA_O,
    input wire        AVS_WAITREQUEST_O,
    input wire        IRQ_O,
    input wire        SCL_OE_O,
    input wire        SDA_OE_O
);
    reg irq_en_q;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ------------------------------------------------------------
    // Helper and assertions
    // ------------------------------------------------------------
    // Shadow of the interrupt enable, so IRQ can be tied to its cause
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            irq_en_q <= 1'b0;
        end else if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 5'h00 && AVS_BYTEENABLE_I[0]) begin
            irq_en_q <= AVS_WRITEDATA_I[6];
        end
    end
    AST_RD_WAIT: assert property ($rose(AVS_READ_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("read wait not one cycle");
    AST_WR_WAIT: assert property ($rose(AVS_WRITE_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("write wait not one cycle");
    AST_RD_UPPER: assert property (AVS_READ_I && !AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_UNMAPPED: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I > 5'h10
        |-> AVS_READDATA_O == 32'h00000000)
        else $error("unmapped read not zero");
    AST_IRQ_EN: assert property (IRQ_O |-> irq_en_q)
        else $error("irq without enable");
    AST_IRQ_FALL: assert property ($fell(IRQ_O) |-> $past(AVS_WRITE_I))
        else $error("irq dropped without a write");
    AST_RST_IDLE: assert property ($rose(RST_N_I) |-> !SCL_OE_O && !SDA_OE_O)
        else $error("lines not released after reset");
    // SDA pulled while SCL released only happens at a start
    AST_START: assert property ($rose(SDA_OE_O) && !SCL_OE_O |-> SDA_OE_O throughout (##[1:400] SCL_OE_O))
        else $error("start not followed by clock low");
    AST_STOP: assert property ($fell(SDA_OE_O) && !SCL_OE_O && !$past(SCL_OE_O)
        |-> ##1 !SCL_OE_O && !SDA_OE_O)
        else $error("stop not left released");
    cover property ($rose(IRQ_O));
    cover property ($fell(SDA_OE_O) && !SCL_OE_O);
    cover property (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I > 5'h10);
endmodule
bind imr_master imr_master_sva #(.QTR_BASE(QTR_BASE)) imr_master_sva_inst (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .IRQ_O(IRQ_O),
    .SCL_OE_O(SCL_OE_O), .SDA_OE_O(SDA_OE_O));

// file: bench/imr_master_tb.sv
// Purpose: Self-checking bench for a master read transaction
// Assumes: Quarter bit period shortened to 2 clocks
// Notes:   Register accesses go through one bus task
`timescale 1ns/1ps
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin mismatches = mismatches + 1; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
module imr_master_tb;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [4:0]  adr = 5'h00;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [31:0] wd = 32'h0;
    reg  [7:0]  v = 8'h00;
    wire [31:0] rdat;
    wire        wt, irq, scl_oe, sda_oe, slv_oe, slv_done;
    wire [7:0]  slv_adr;
    wire        scl = !scl_oe;
    wire        sda = !(sda_oe || slv_oe);
    integer     mismatches = 0;
    integer     checks = 0;
    integer     cyc = 0;
    // ------------------------------------------------------------
    // Clock, design, partner, tasks
    // ------------------------------------------------------------
    always #2.5 clk = !clk;
    imr_master #(.QTR_BASE(2)) imr_master_inst (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'h1), .AVS_WRITEDATA_I(wd),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt), .IRQ_O(irq), .SCL_I(scl), .SCL_O(),
        .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe));
    imr_slave_model imr_slave_model_inst (.scl_i(scl), .sda_i(sda), .sda_oe_o(slv_oe), .addr_o(slv_adr),
        .done_o(slv_done));
    // One access; waitrequest and read data taken at the rising edge
    task xfer(input w, input [4:0] a, input [7:0] d);
        begin
            @(posedge clk);
            wr <= w;
            rd <= !w;
            adr <= a;
            wd <= {24'h000000, d};
            @(posedge clk);
            while (wt !== 1'b0) @(posedge clk);
            v = rdat[7:0];
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    // Bounded poll of one register bit
    task poll(input [4:0] a, input integer b, input val);
        integer n;
        begin
            n = 0;
            xfer(1'b0, a, 8'h00);
            while (v[b] !== val && n < 300) begin
                xfer(1'b0, a, 8'h00);
                n = n + 1;
            end
            `CHK(v[b], val)
        end
    endtask
    task stop_test;
        begin
            if (mismatches == 0 && checks > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            stop_test;
        end
    end
    // Read transaction: start, address, three bytes, stop
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        xfer(1'b0, 5'h00, 8'h00);
        `CHK(v, 8'h02)
        xfer(1'b0, 5'h14, 8'h00);
        `CHK(v, 8'h00)
        xfer(1'b1, 5'h0c, 8'h5a);
        xfer(1'b0, 5'h0c, 8'h00);
        `CHK(v, 8'h5a)
        xfer(1'b1, 5'h00, 8'hf2);
        xfer(1'b0, 5'h0c, 8'h00);
        `CHK(v, 8'h00)
        xfer(1'b0, 5'h00, 8'h00);
        `CHK(v, 8'hf2)
        `CHK(irq, 1'b0)
        xfer(1'b1, 5'h00, 8'hf4);
        poll(5'h00, 0, 1'b1);
        xfer(1'b0, 5'h04, 8'h00);
        `CHK(v[6], 1'b1)
        xfer(1'b0, 5'h00, 8'h00);
        `CHK(v[2], 1'b1)
        `CHK(irq, 1'b1)
        xfer(1'b1, 5'h08, 8'ha1);
        xfer(1'b1, 5'h00, 8'hf6);
        poll(5'h00, 0, 1'b1);
        `CHK(slv_adr, 8'ha1)
        xfer(1'b0, 5'h04, 8'h00);
        `CHK(v[0], 1'b0)
        xfer(1'b1, 5'h00, 8'he6);
        xfer(1'b0, 5'h08, 8'h00);
        poll(5'h00, 0, 1'b1);
        xfer(1'b0, 5'h04, 8'h00);
        `CHK(v[7], 1'b1)
        repeat (120) @(posedge clk);
        `CHK(scl, 1'b0)
        xfer(1'b0, 5'h08, 8'h00);
        `CHK(v, 8'hc3)
        xfer(1'b0, 5'h04, 8'h00);
        `CHK(v[7], 1'b0)
        xfer(1'b1, 5'h00, 8'he6);
        poll(5'h00, 0, 1'b1);
        xfer(1'b1, 5'h04, 8'h01);
        xfer(1'b0, 5'h08, 8'h00);
        `CHK(v, 8'hc4)
        xfer(1'b1, 5'h00, 8'he6);
        poll(5'h00, 0, 1'b1);
        `CHK(slv_done, 1'b1)
        xfer(1'b1, 5'h00, 8'hf6);
        xfer(1'b0, 5'h04, 8'h00);
        `CHK(v[6], 1'b1)
        xfer(1'b0, 5'h08, 8'h00);
        `CHK(v, 8'hc5)
        xfer(1'b1, 5'h00, 8'hf0);
        poll(5'h00, 2, 1'b0);
        xfer(1'b0, 5'h04, 8'h00);
        `CHK(v[6], 1'b0)
        `CHK({scl, sda}, 2'b11)
        stop_test;
    end
endmodule

// file: bench/imr_slave_model.sv
// Purpose: Behavioural slave that acks its address and sends bytes
// Assumes: Lines pulled up; model only pulls SDA low
// Notes:   Next byte is the last plus one, only after a master ack
`timescale 1ns/1ps
module imr_slave_model #(
    parameter [7:0] FIRST_BYTE = 8'hc3
) (
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_oe_o = 1'b0,
    output reg  [7:0] addr_o = 8'h00,
    output reg        done_o = 1'b0
);
    integer   pos = 0;
    reg       act = 1'b0;
    reg       adr_ph = 1'b0;
    reg       rd = 1'b0;
    reg [7:0] sh = 8'h00;
    reg [7:0] tx = FIRST_BYTE;
    // ------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------
    // SDA moving while SCL high marks start (fall) or stop (rise)
    always @(sda_i) begin
        if (scl_i) begin
            act = !sda_i;
            adr_ph = !sda_i;
            pos = 0;
            sda_oe_o = 1'b0;
        end
    end
    // Sample on rising SCL; master ack decides whether to go on
    always @(posedge scl_i) begin
        if (act) begin
            pos = pos + 1;
            if (pos <= 8) sh = {sh[6:0], sda_i};
            if (adr_ph && pos == 9) addr_o = sh;
            if (adr_ph && pos == 9) rd = sh[0];
            if (!adr_ph && rd && pos == 9 && sda_i) done_o = 1'b1;
            if (!adr_ph && rd && pos == 9 && !sda_i) tx = tx + 8'h01;
        end
    end
    // Change SDA only while SCL is low: ack, then data MSB first
    always @(negedge scl_i) begin
        if (act) begin
            if (pos == 9) adr_ph = 1'b0;
            if (pos == 9) pos = 0;
            sda_oe_o = adr_ph ? (pos == 8) : (rd && !done_o && pos < 8 && !tx[7 - pos]);
        end
    end
endmodule

// file: logic/imr_defines.vh
// Purpose: Shared constants for the two-wire master receive sequencer
// Assumes: Byte addresses on a 32-bit Avalon-MM slave port
// Notes:   Definitions only
`ifndef IMR_DEFINES_VH
`define IMR_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IMR_OFS_CTRL      5'h00
`define IMR_OFS_STAT      5'h04
`define IMR_OFS_DATA      5'h08
`define IMR_OFS_MODE      5'h0c
`define IMR_OFS_TIMER     5'h10

// ----------------------------------------------------------------
// Link control register fields
// ----------------------------------------------------------------
`define IMR_CTL_CORE_ON   7
`define IMR_CTL_IRQ_EN    6
`define IMR_CTL_MASTER    5
`define IMR_CTL_TRANSMIT  4
`define IMR_CTL_ACK_CHK   3
`define IMR_CTL_BUSY      2
`define IMR_CTL_GATE      1
`define IMR_CTL_EVENT     0

// ----------------------------------------------------------------
// Link status register fields
// ----------------------------------------------------------------
`define IMR_STA_RX_FULL   7
`define IMR_STA_TX_EMPTY  6
`define IMR_STA_ARB_LOST  5
`define IMR_STA_ACK_ERR   4
`define IMR_STA_ACK       0

// ----------------------------------------------------------------
// Link mode register fields
// ----------------------------------------------------------------
`define IMR_MOD_BIT_ORDER 7
`define IMR_MOD_WAIT      6
`define IMR_MOD_DIV_HI    2
`define IMR_MOD_DIV_LO    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IMR_RST_BYTE      8'h00
`define IMR_RST_ACK       1'b0

// ----------------------------------------------------------------
// Timing: base quarter of a bus clock period
// ----------------------------------------------------------------
`define IMR_CLK_MHZ       200
`define IMR_QTR_NS        125
`define IMR_QTR_CYC       ((`IMR_QTR_NS * `IMR_CLK_MHZ) / 1000)
`define IMR_LAST_BIT      4'h8

`endif

// file: logic/imr_master.v
// Purpose: Two-wire bus master sequencer with start, address, receive, stop
// Assumes: Open-drain lines resolved outside; slave mode only as mode bits
// Notes on behaviour
// - Busy flag reads 0 when bus released
// - Master and transmit bits set give transmitter
// - One write master=1 busy=1 gate=0 issues start
// - Start detected sets event and transmit-empty
// - Data write in transmit clears transmit-empty
// - Holding byte moves into shift stage
// - Transmit: event at ninth clock rising edge
// - Interrupt when event flag and enable
// - Ninth clock acknowledge loads acknowledge bit
// - Clearing transmit bit selects master reception
// - Reception drives acknowledge bit in slot
// - Dummy data read starts first reception
// - Reception: event and receive-full at ninth
// - Next byte waits until receive-full clears
// - Data read returns byte, clears receive-full
// - Transmit bit set ends reception, sets empty
// - Acknowledge check stops transfer on NACK
// - Bus rate from range and divider bits
// - Bit order and wait zero: MSB first
// - Lost arbitration drops to slave reception
// - Core-on selects own-address or mode/data view
// - One write master=1 busy=0 gate=0 issues stop
`timescale 1ns/1ps
`include "imr_defines.vh"

module imr_master #(
    parameter QTR_BASE = `IMR_QTR_CYC
) (
    input  wire        CLK_I,
    input  wire        RST_N_I,
    input  wire [4:0]  AVS_ADDRESS_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [3:0]  AVS_BYTEENABLE_I,
    input  wire [31:0] AVS_WRITEDATA_I,
    output reg  [31:0] AVS_READDATA_O,
    output wire        AVS_WAITREQUEST_O,
    output wire        IRQ_O,
    input  wire        SCL_I,
    output wire        SCL_O,
    output wire        SCL_OE_O,
    input  wire        SDA_I,
    output wire        SDA_O,
    output wire        SDA_OE_O
);

// ----------------------------------------------------------------
// Engine states
// ----------------------------------------------------------------
localparam S_IDLE  = 3'd0;
localparam S_START = 3'd1;
localparam S_HOLD  = 3'd2;
localparam S_BIT   = 3'd3;
localparam S_STOP  = 3'd4;

// Bit index to shift position for either bit order
function [2:0] bit_pos;
    input [3:0] idx;
    input       lsb_first;
    begin
        bit_pos = lsb_first ? idx[2:0] : (3'd7 - idx[2:0]);
    end
endfunction

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg        ack_q;
reg        core_on_q, irq_en_q, master_q, transmit_q, ack_chk_q;
reg        busy_q, event_q, rx_full_q, tx_empty_q, arb_lost_q, ack_err_q;
reg        ack_val_q, bit_order_q, wait_q;
reg [2:0]  div_sel_q;
reg [1:0]  rate_q;
reg [7:0]  own_addr_q, own_addr2_q, hold_q, shift_q, rx_byte_q;
reg        start_req_q, stop_req_q, rx_arm_q, rx_mode_q, tx_frame_q;
reg [2:0]  state_q;
reg [1:0]  qtr_q;
reg [3:0]  bit_q;
reg [15:0] div_cnt_q;
reg        scl_low_q, sda_low_q;
reg        scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_d_q, scl_d_q;
wire       do_wr, do_rd, wr_lane, ctl_wr, sta_wr, dat_wr, dat_rd, mod_wr;
wire       tim_wr, tick, start_seen, stop_seen, arb_hit, ninth_rise;
wire [15:0] qtr_len;
wire [7:0] ctl_rd, sta_rd, mod_rd, wd;

// ----------------------------------------------------------------
// Avalon-MM slave: one wait cycle per access
// ----------------------------------------------------------------
// Access completes on the edge where ack_q is high
assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
assign do_wr   = AVS_WRITE_I & ack_q;
assign do_rd   = AVS_READ_I & ack_q;
assign wr_lane = do_wr & AVS_BYTEENABLE_I[0];
assign wd      = AVS_WRITEDATA_I[7:0];
assign ctl_wr  = wr_lane & (AVS_ADDRESS_I == `IMR_OFS_CTRL);
assign sta_wr  = wr_lane & (AVS_ADDRESS_I == `IMR_OFS_STAT);
assign dat_wr  = wr_lane & (AVS_ADDRESS_I == `IMR_OFS_DATA) & core_on_q;
assign mod_wr  = wr_lane & (AVS_ADDRESS_I == `IMR_OFS_MODE) & core_on_q;
assign tim_wr  = wr_lane & (AVS_ADDRESS_I == `IMR_OFS_TIMER);
assign dat_rd  = do_rd & (AVS_ADDRESS_I == `IMR_OFS_DATA) & core_on_q;

assign ctl_rd = {core_on_q, irq_en_q, master_q, transmit_q, ack_chk_q, busy_q, 1'b1, event_q};
assign sta_rd = {rx_full_q, tx_empty_q, arb_lost_q, ack_err_q, 3'b000, ack_val_q};
assign mod_rd = {bit_order_q, wait_q, 3'b000, div_sel_q};

// Read data registered in the wait cycle so it stands at the answer edge
always @(posedge CLK_I) begin
    ack_q <= RST_N_I & (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    if (!RST_N_I) begin
        AVS_READDATA_O <= 32'h0000_0000;
    end else if (AVS_READ_I & ~ack_q) begin
        case (AVS_ADDRESS_I)
            `IMR_OFS_CTRL:  AVS_READDATA_O <= {24'h00_0000, ctl_rd};
            `IMR_OFS_STAT:  AVS_READDATA_O <= {24'h00_0000, sta_rd};
            `IMR_OFS_DATA:  AVS_READDATA_O <= {24'h00_0000, core_on_q ? rx_byte_q : own_addr2_q};
            `IMR_OFS_MODE:  AVS_READDATA_O <= {24'h00_0000, core_on_q ? mod_rd : own_addr_q};
            `IMR_OFS_TIMER: AVS_READDATA_O <= {30'h0000_0000, rate_q};
            default:        AVS_READDATA_O <= 32'h0000_0000;
        endcase
    end
end

// Interrupt is a plain level of flag and enable
assign IRQ_O = event_q & irq_en_q;

// ----------------------------------------------------------------
// Line synchronisers and condition detectors
// ----------------------------------------------------------------
// Two flops per line; third stage only for edge detection
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        scl_m_q <= 1'b1;
        scl_s_q <= 1'b1;
        scl_d_q <= 1'b1;
        sda_m_q <= 1'b1;
        sda_s_q <= 1'b1;
        sda_d_q <= 1'b1;
    end else begin
        scl_m_q <= SCL_I;
        scl_s_q <= scl_m_q;
        scl_d_q <= scl_s_q;
        sda_m_q <= SDA_I;
        sda_s_q <= sda_m_q;
        sda_d_q <= sda_s_q;
    end
end

assign start_seen = sda_d_q & ~sda_s_q & scl_s_q & scl_d_q;
assign stop_seen  = ~sda_d_q & sda_s_q & scl_s_q & scl_d_q;

// Lines are only ever pulled low; a high is a released pin
assign SCL_O    = 1'b0;
assign SDA_O    = 1'b0;
assign SCL_OE_O = scl_low_q;
assign SDA_OE_O = sda_low_q;

// ----------------------------------------------------------------
// Bus clock divider: quarter-period tick
// ----------------------------------------------------------------
// Quarter length scales by 2^divider times (range + 1)
assign qtr_len = (QTR_BASE[15:0] << div_sel_q) * {13'h0000, {1'b0, rate_q} + 3'b001};
assign tick    = (div_cnt_q >= qtr_len - 16'h0001);

always @(posedge CLK_I) begin
    if (!RST_N_I || state_q == S_IDLE && !start_req_q || tick) begin
        div_cnt_q <= 16'h0000;
    end else begin
        div_cnt_q <= div_cnt_q + 16'h0001;
    end
end

// Arbitration loss: released data bit seen low at the high clock phase
assign arb_hit    = tick & (state_q == S_BIT) & (qtr_q == 2'd2) & scl_s_q & tx_frame_q &
                    (bit_q != `IMR_LAST_BIT) & ~sda_low_q & ~sda_s_q;
assign ninth_rise = tick & (state_q == S_BIT) & (qtr_q == 2'd2) & scl_s_q & (bit_q == `IMR_LAST_BIT);

// ----------------------------------------------------------------
// Software-owned configuration
// ----------------------------------------------------------------
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        core_on_q   <= 1'b0;
        irq_en_q    <= 1'b0;
        ack_chk_q   <= 1'b0;
        bit_order_q <= 1'b0;
        wait_q      <= 1'b0;
        div_sel_q   <= 3'b000;
        rate_q      <= 2'b00;
        own_addr_q  <= `IMR_RST_BYTE;
        own_addr2_q <= `IMR_RST_BYTE;
        hold_q      <= `IMR_RST_BYTE;
    end else begin
        if (ctl_wr) begin
            core_on_q <= wd[`IMR_CTL_CORE_ON];
            irq_en_q  <= wd[`IMR_CTL_IRQ_EN];
            ack_chk_q <= wd[`IMR_CTL_ACK_CHK];
        end
        if (mod_wr) begin
            bit_order_q <= wd[`IMR_MOD_BIT_ORDER];
            wait_q      <= wd[`IMR_MOD_WAIT];
            div_sel_q   <= wd[`IMR_MOD_DIV_HI:`IMR_MOD_DIV_LO];
        end
        // Own-address view only while the core is off
        if (wr_lane && !core_on_q && AVS_ADDRESS_I == `IMR_OFS_MODE) begin
            own_addr_q <= wd;
        end
        if (wr_lane && !core_on_q && AVS_ADDRESS_I == `IMR_OFS_DATA) begin
            own_addr2_q <= wd;
        end
        if (tim_wr) begin
            rate_q <= wd[1:0];
        end
        if (dat_wr && transmit_q) begin
            hold_q <= wd;
        end
    end
end

// ----------------------------------------------------------------
// Mode bits and flags: hardware sets win over software clears
// ----------------------------------------------------------------
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        master_q    <= 1'b0;
        transmit_q  <= 1'b0;
        busy_q      <= 1'b0;
        event_q     <= 1'b0;
        rx_full_q   <= 1'b0;
        tx_empty_q  <= 1'b0;
        arb_lost_q  <= 1'b0;
        ack_err_q   <= 1'b0;
        ack_val_q   <= `IMR_RST_ACK;
        start_req_q <= 1'b0;
        stop_req_q  <= 1'b0;
        rx_arm_q    <= 1'b0;
    end else begin
        if (ctl_wr) begin
            master_q   <= wd[`IMR_CTL_MASTER];
            transmit_q <= wd[`IMR_CTL_TRANSMIT];
            if (!wd[`IMR_CTL_EVENT]) begin
                event_q <= 1'b0;
            end
            // Master, busy and gate in one write: master=1 busy=1 gate=0 start, master=1 busy=0 gate=0 stop
            if (!wd[`IMR_CTL_GATE] && wd[`IMR_CTL_MASTER]) begin
                start_req_q <= wd[`IMR_CTL_BUSY] & ~busy_q;
                stop_req_q  <= ~wd[`IMR_CTL_BUSY] & busy_q;
            end
        end
        if (sta_wr) begin
            ack_val_q <= wd[`IMR_STA_ACK];
        end
        if (dat_wr && transmit_q) begin
            tx_empty_q <= 1'b0;
        end
        if (dat_rd) begin
            rx_full_q <= 1'b0;
            rx_arm_q  <= ~transmit_q & master_q;
        end
        if (state_q == S_START) begin
            start_req_q <= 1'b0;
        end
        if (state_q == S_STOP) begin
            stop_req_q <= 1'b0;
        end
        if (state_q == S_HOLD && !transmit_q && rx_arm_q && !rx_full_q) begin
            rx_arm_q <= 1'b0;
        end
        // Bus line events
        if (start_seen) begin
            busy_q     <= 1'b1;
            event_q    <= 1'b1;
            tx_empty_q <= 1'b1;
            arb_lost_q <= 1'b0;
        end
        if (stop_seen) begin
            busy_q     <= 1'b0;
            tx_empty_q <= 1'b0;
            ack_err_q  <= 1'b0;
            rx_arm_q   <= 1'b0;
        end
        // Transmit bit set after a received byte ends the reception
        if (state_q == S_HOLD && transmit_q && rx_mode_q) begin
            tx_empty_q <= 1'b1;
        end
        if (state_q == S_HOLD && transmit_q && master_q && !tx_empty_q && !ack_err_q && busy_q) begin
            tx_empty_q <= 1'b1;  // holding free again once shifted
        end
        if (ninth_rise) begin
            event_q <= 1'b1;
            if (tx_frame_q) begin
                ack_val_q <= sda_s_q;
                ack_err_q <= ack_chk_q & sda_s_q;
            end else begin
                rx_full_q <= 1'b1;
            end
        end
        // Lost bus: fall back to slave reception with preset acknowledge
        if (arb_hit) begin
            master_q   <= 1'b0;
            transmit_q <= 1'b0;
            event_q    <= 1'b1;
            arb_lost_q <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Bus sequencer
// ----------------------------------------------------------------
// Limitation: wait insertion bit is stored only; no wait states inserted
always @(posedge CLK_I) begin
    if (!RST_N_I || !core_on_q) begin
        state_q    <= S_IDLE;
        qtr_q      <= 2'd0;
        bit_q      <= 4'h0;
        scl_low_q  <= 1'b0;
        sda_low_q  <= 1'b0;
        shift_q    <= `IMR_RST_BYTE;
        rx_byte_q  <= `IMR_RST_BYTE;
        tx_frame_q <= 1'b0;
        rx_mode_q  <= 1'b0;
    end else if (arb_hit) begin
        state_q   <= S_IDLE;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
    end else begin
        case (state_q)
            S_IDLE: begin
                qtr_q <= 2'd0;
                if (start_req_q && !busy_q && tick) begin
                    state_q <= S_START;
                end
            end
            S_START: begin
                // Data falls while clock high, then clock falls
                if (tick) begin
                    if (!sda_low_q) begin
                        sda_low_q <= 1'b1;
                    end else begin
                        scl_low_q <= 1'b1;
                        state_q   <= S_HOLD;
                    end
                end
            end
            S_HOLD: begin
                qtr_q <= 2'd0;
                bit_q <= 4'h0;
                if (stop_req_q) begin
                    state_q <= S_STOP;
                end else if (transmit_q && rx_mode_q) begin
                    rx_mode_q <= 1'b0;
                end else if (transmit_q && master_q && !tx_empty_q && !ack_err_q && busy_q) begin // own start seen
                    shift_q    <= hold_q;
                    tx_frame_q <= 1'b1;
                    state_q    <= S_BIT;
                end else if (!transmit_q && master_q && rx_arm_q && !rx_full_q) begin
                    tx_frame_q <= 1'b0;
                    rx_mode_q  <= 1'b1;
                    state_q    <= S_BIT;
                end
            end
            S_BIT: begin
                if (tick) begin
                    case (qtr_q)
                        2'd0: begin
                            // Set data while clock is low
                            if (bit_q == `IMR_LAST_BIT) begin
                                sda_low_q <= ~tx_frame_q & ~ack_val_q;
                            end else begin
                                sda_low_q <= tx_frame_q & ~shift_q[bit_pos(bit_q, bit_order_q)];
                            end
                            qtr_q <= 2'd1;
                        end
                        2'd1: begin
                            scl_low_q <= 1'b0;
                            qtr_q     <= 2'd2;
                        end
                        2'd2: begin
                            // Holds here while a slave stretches the clock
                            if (scl_s_q) begin
                                if (!tx_frame_q && bit_q != `IMR_LAST_BIT) begin
                                    rx_byte_q[bit_pos(bit_q, bit_order_q)] <= sda_s_q;
                                end
                                qtr_q <= 2'd3;
                            end
                        end
                        default: begin
                            scl_low_q <= 1'b1;
                            qtr_q     <= 2'd0;
                            if (bit_q == `IMR_LAST_BIT) begin
                                sda_low_q <= 1'b0;
                                state_q   <= S_HOLD;
                            end else begin
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    endcase
                end
            end
            S_STOP: begin
                // Data low, release clock, then release data while clock high
                if (tick) begin
                    case (qtr_q)
                        2'd0: begin
                            sda_low_q <= 1'b1;
                            qtr_q     <= 2'd1;
                        end
                        2'd1: begin
                            scl_low_q <= 1'b0;
                            qtr_q     <= 2'd2;
                        end
                        default: begin
                            if (scl_s_q) begin
                                sda_low_q <= 1'b0;
                                state_q   <= S_IDLE;
                            end
                        end
                    endcase
                end
            end
            default: begin
                state_q <= S_IDLE;
            end
        endcase
    end
end

endmodule
